// ### ibus_pkg.sv
// Function
// - Own address accepted only in range 0 to 30.
// - Address retained; fall back to 3 when stored value is lost.
// - Addressable mode with controller: act as talker and listener.
// - Output-only mode transmits only, never listens.
// - Command bytes decoded apart from text data.
// - Every byte under ATN is an interface command.
// - Universal clear drops errors, pending work and both buffers.
// - EOI with listener and no ATN marks last data byte.
// - Trigger while listening aborts and restarts measurement.
// - Go-to-local while listening returns local, lockout kept.
// - Interface clear unaddresses talker and listener, goes idle.
// - Listen address matching own address makes listener.
// - Talk address matching own address makes talker.
// - Lockout in remote disables local key and panel keys.
// - Remote enable release: go local, clear lockout.
// - Null command byte has no effect.
// - Remote enable asserted: enter remote, obey commands as listener.
// - Selected clear while listener acts like universal clear.
// - Poll enable: talker sends status byte instead of data.
// - Poll disable: leave poll state, send data again.
// - Unlisten drops listener; only together with all listeners.
// - Untalk or other talk address drops talker.
// - Service request asserted when an enabled status bit is true.
// - Never respond to parallel poll.
// - Local key returns local only when lockout is inactive.
package ibus_pkg;
	// ************************************************************
	// Command encodings
	// ************************************************************
	localparam logic [7:0] CMD_NULL = 8'h00;
	localparam logic [7:0] CMD_GO_LOCAL = 8'h01;
	localparam logic [7:0] CMD_SEL_CLEAR = 8'h04;
	localparam logic [7:0] CMD_TRIGGER = 8'h08;
	localparam logic [7:0] CMD_LOCKOUT = 8'h11;
	localparam logic [7:0] CMD_DEV_CLEAR = 8'h14;
	localparam logic [7:0] CMD_POLL_ON = 8'h18;
	localparam logic [7:0] CMD_POLL_OFF = 8'h19;
	localparam logic [7:0] CMD_UNLISTEN = 8'h3f;
	localparam logic [7:0] CMD_UNTALK = 8'h5f;
	localparam logic [2:0] GRP_LISTEN = 3'h1;
	localparam logic [2:0] GRP_TALK = 3'h2;
	localparam int GRP_HI = 7;
	localparam int GRP_LO = 5;
	// ************************************************************
	// Address, data width and buffer depth settings
	// ************************************************************
	localparam logic [4:0] ADDR_MAX = 5'h1e;
	localparam logic [4:0] ADDR_DEFAULT = 5'h03;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 8;
	// Bus byte with end flag
	typedef struct packed {
		logic eoi;
		logic [7:0] data;
	} bus_byte_s;
endpackage : ibus_pkg

// ### ibus_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ibus_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	// Clock and control
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic flush,
	// Fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic doWr;
	logic doRd;
	// Handshake terms
	assign inReady = (count != (AW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];
	assign doWr = inValid && inReady;
	assign doRd = outValid && outReady;
	// Storage
	always_ff @(posedge core_clk) begin
		if (clkEn && doWr) begin
			mem[wrPtr] <= inData;
		end
	end
	// Pointers; flush empties at once
	always_ff @(posedge core_clk) begin
		if (reset || (clkEn && flush)) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else if (clkEn) begin
			if (doWr) begin
				wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
			end
			if (doRd) begin
				rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
		end
	end
endmodule : ibus_fifo
`default_nettype wire

// ### ibus_iface.sv
`timescale 1ns/1ps
`default_nettype none
module ibus_iface #(
	parameter int FIFO_DEPTH = ibus_pkg::FIFO_DEPTH
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clkEn,
	// Configuration
	input wire logic [4:0] cfgAddr,
	input wire logic cfgAddrValid,
	input wire logic talkOnly,
	// Bus side
	input wire logic atn,
	input wire logic ren,
	input wire logic ifc,
	input wire logic byteValid,
	input wire ibus_pkg::bus_byte_s busByte,
	// Front panel
	input wire logic localKey,
	// Status for service request
	input wire logic [7:0] statusBits,
	input wire logic [7:0] statusEnable,
	// Data drain to instrument
	output logic dataValid,
	input wire logic dataReady,
	output ibus_pkg::bus_byte_s dataByte,
	output logic inReady,
	// State outputs
	output logic [4:0] myAddr,
	output logic listener,
	output logic talker,
	output logic remote,
	output logic lockout,
	output logic pollMode,
	output logic sendStatus,
	output logic srq,
	output logic ppResponse,
	output logic clearPulse,
	output logic triggerPulse,
	output logic lastByte
);
	// ************************************************************
	// Command decode
	// ************************************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACTIVE = 2'b01
	} if_state_e;
	if_state_e state;
	logic cmdStrobe;
	logic dataStrobe;
	logic [7:0] cmd;
	logic isListenAddr;
	logic isTalkAddr;
	logic addrHit;
	logic doClear;
	logic fifoInReady;
	logic fifoValid;
	logic [8:0] fifoData;
	logic next_remote;
	assign cmd = busByte.data;
	// Under ATN every byte is a command, never data
	assign cmdStrobe = byteValid && atn;
	assign dataStrobe = byteValid && !atn && listener && !talkOnly;
	assign isListenAddr = cmd[ibus_pkg::GRP_HI:ibus_pkg::GRP_LO] ==
		ibus_pkg::GRP_LISTEN;
	assign isTalkAddr = cmd[ibus_pkg::GRP_HI:ibus_pkg::GRP_LO] ==
		ibus_pkg::GRP_TALK;
	assign addrHit = cmd[4:0] == myAddr;
	assign doClear = cmdStrobe && (cmd == ibus_pkg::CMD_DEV_CLEAR ||
		(cmd == ibus_pkg::CMD_SEL_CLEAR && listener));
	// Address store; bad or lost value falls back to default
	always_ff @(posedge core_clk) begin
		if (reset) begin
			myAddr <= ibus_pkg::ADDR_DEFAULT;
		end else if (clkEn) begin
			if (!cfgAddrValid || cfgAddr > ibus_pkg::ADDR_MAX) begin
				myAddr <= ibus_pkg::ADDR_DEFAULT;
			end else begin
				myAddr <= cfgAddr;
			end
		end
	end
	// Interface state: idle after clear until next command
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state <= ST_IDLE;
		end else if (clkEn) begin
			case (state)
				ST_IDLE: begin
					if (cmdStrobe && !ifc) begin
						state <= ST_ACTIVE;
					end
				end
				ST_ACTIVE: begin
					if (ifc) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
	// Listener addressing; output-only never listens
	always_ff @(posedge core_clk) begin
		if (reset) begin
			listener <= 1'b0;
		end else if (clkEn) begin
			if (ifc || talkOnly) begin
				listener <= 1'b0;
			end else if (cmdStrobe) begin
				if (cmd == ibus_pkg::CMD_UNLISTEN) begin
					listener <= 1'b0;
				end else if (isListenAddr && addrHit) begin
					listener <= 1'b1;
				end
			end
		end
	end
	// Talker addressing; output-only is always talking
	always_ff @(posedge core_clk) begin
		if (reset) begin
			talker <= 1'b0;
		end else if (clkEn) begin
			if (talkOnly) begin
				talker <= 1'b1;
			end else if (ifc) begin
				talker <= 1'b0;
			end else if (cmdStrobe) begin
				if (cmd == ibus_pkg::CMD_UNTALK) begin
					talker <= 1'b0;
				end else if (isTalkAddr) begin
					talker <= addrHit;
				end
			end
		end
	end
	// Remote follows enable; non-null commands when listening
	always_comb begin
		next_remote = remote;
		if (!ren) begin
			next_remote = 1'b0;
		end else if (cmdStrobe && cmd == ibus_pkg::CMD_GO_LOCAL &&
			listener) begin
			next_remote = 1'b0;
		end else if (localKey && !lockout) begin
			next_remote = 1'b0;
		end else if (cmdStrobe && listener &&
			cmd != ibus_pkg::CMD_NULL) begin
			next_remote = 1'b1;
		end else if (cmdStrobe && isListenAddr && addrHit) begin
			next_remote = 1'b1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			remote <= 1'b0;
		end else if (clkEn) begin
			remote <= next_remote;
		end
	end
	// Lockout cleared only by release of remote enable
	always_ff @(posedge core_clk) begin
		if (reset) begin
			lockout <= 1'b0;
		end else if (clkEn) begin
			if (!ren) begin
				lockout <= 1'b0;
			end else if (cmdStrobe && cmd == ibus_pkg::CMD_LOCKOUT) begin
				lockout <= 1'b1;
			end
		end
	end
	// Serial poll state
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pollMode <= 1'b0;
			sendStatus <= 1'b0;
		end else if (clkEn) begin
			if (ifc || (cmdStrobe && cmd == ibus_pkg::CMD_POLL_OFF)) begin
				pollMode <= 1'b0;
			end else if (cmdStrobe && cmd == ibus_pkg::CMD_POLL_ON) begin
				pollMode <= 1'b1;
			end
			sendStatus <= next_poll_talk(pollMode, talker);
		end
	end
	function automatic logic next_poll_talk(input logic p, input logic t);
		next_poll_talk = p && t;
	endfunction : next_poll_talk
	// Event pulses and service request
	always_ff @(posedge core_clk) begin
		if (reset) begin
			clearPulse <= 1'b0;
			triggerPulse <= 1'b0;
			srq <= 1'b0;
			ppResponse <= 1'b0;
			lastByte <= 1'b0;
		end else if (clkEn) begin
			clearPulse <= doClear;
			triggerPulse <= cmdStrobe && listener &&
				cmd == ibus_pkg::CMD_TRIGGER;
			srq <= |(statusBits & statusEnable);
			ppResponse <= 1'b0;
			lastByte <= dataStrobe && busByte.eoi;
		end
	end
	// ************************************************************
	// Input buffer
	// ************************************************************
	// Clear flushes pending bytes; the drain can stall to fill it
	ibus_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.reset(reset),
		.clkEn(clkEn),
		.flush(doClear || ifc),
		.inValid(dataStrobe),
		.inReady(fifoInReady),
		.inData(busByte),
		.outValid(fifoValid),
		.outReady(dataReady && !dataValid),
		.outData(fifoData)
	);
	// Output stage registered
	always_ff @(posedge core_clk) begin
		if (reset) begin
			dataValid <= 1'b0;
			dataByte <= '0;
			inReady <= 1'b0;
		end else if (clkEn) begin
			inReady <= fifoInReady && !talkOnly;
			if (doClear) begin
				dataValid <= 1'b0;
			end else if (!dataValid && fifoValid && dataReady) begin
				dataValid <= 1'b1;
				dataByte <= fifoData;
			end else if (dataValid) begin
				dataValid <= 1'b0;
			end
		end
	end
	// ************************************************************
	// Checks
	// ************************************************************
	property p_talkonly_no_listen;
		@(posedge core_clk) disable iff (reset)
		talkOnly && clkEn |=> !listener;
	endproperty
	a_talkonly_no_listen: assert property (p_talkonly_no_listen)
		else $error("listener set in output-only mode");
	property p_untalk;
		@(posedge core_clk) disable iff (reset)
		clkEn && cmdStrobe && cmd == ibus_pkg::CMD_UNTALK && !talkOnly
		|=> !talker;
	endproperty
	a_untalk: assert property (p_untalk)
		else $error("talker kept after untalk");
	property p_ifc;
		@(posedge core_clk) disable iff (reset)
		clkEn && ifc && !talkOnly |=> !listener && !talker;
	endproperty
	a_ifc: assert property (p_ifc)
		else $error("addressing kept after interface clear");
	property p_ren_off;
		@(posedge core_clk) disable iff (reset)
		clkEn && !ren |=> !remote && !lockout;
	endproperty
	a_ren_off: assert property (p_ren_off)
		else $error("remote kept after enable release");
	property p_gtl_lock;
		@(posedge core_clk) disable iff (reset)
		clkEn && ren && lockout && cmdStrobe |=> lockout;
	endproperty
	a_gtl_lock: assert property (p_gtl_lock)
		else $error("lockout lost on command");
	property p_srq;
		@(posedge core_clk) disable iff (reset)
		clkEn && |(statusBits & statusEnable) |=> srq;
	endproperty
	a_srq: assert property (p_srq)
		else $error("service request missing");
	property p_pp;
		@(posedge core_clk) disable iff (reset)
		1'b1 |=> !ppResponse;
	endproperty
	a_pp: assert property (p_pp)
		else $error("parallel poll response driven");
	property p_addr;
		@(posedge core_clk) disable iff (reset)
		clkEn |=> myAddr <= ibus_pkg::ADDR_MAX;
	endproperty
	a_addr: assert property (p_addr)
		else $error("address out of range");
	property p_clear;
		@(posedge core_clk) disable iff (reset)
		clkEn && doClear |=> clearPulse && !dataValid;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear not applied");
	property p_listen_addr;
		@(posedge core_clk) disable iff (reset)
		clkEn && cmdStrobe && isListenAddr && addrHit &&
		!ifc && !talkOnly |=> listener;
	endproperty
	a_listen_addr: assert property (p_listen_addr)
		else $error("own listen address not taken");
	property p_talk_hit;
		@(posedge core_clk) disable iff (reset)
		clkEn && cmdStrobe && isTalkAddr && addrHit &&
		!ifc && !talkOnly |=> talker;
	endproperty
	a_talk_hit: assert property (p_talk_hit)
		else $error("own talk address not taken");
	property p_talk_other;
		@(posedge core_clk) disable iff (reset)
		clkEn && cmdStrobe && isTalkAddr && !addrHit &&
		!ifc && !talkOnly |=> !talker;
	endproperty
	a_talk_other: assert property (p_talk_other)
		else $error("talker kept after another talk address");
	property p_trigger;
		@(posedge core_clk) disable iff (reset)
		clkEn && cmdStrobe && listener &&
		cmd == ibus_pkg::CMD_TRIGGER |=> triggerPulse;
	endproperty
	a_trigger: assert property (p_trigger)
		else $error("trigger not raised while listening");
	property p_sel_clear_idle;
		@(posedge core_clk) disable iff (reset)
		clkEn && cmdStrobe && !listener &&
		cmd == ibus_pkg::CMD_SEL_CLEAR |=> !clearPulse;
	endproperty
	a_sel_clear_idle: assert property (p_sel_clear_idle)
		else $error("selected clear taken while not listening");
	property p_null;
		@(posedge core_clk) disable iff (reset)
		clkEn && cmdStrobe && cmd == ibus_pkg::CMD_NULL && ren &&
		!ifc && !talkOnly && !localKey
		|=> $stable(listener) && $stable(talker) && $stable(remote) &&
		$stable(lockout) && $stable(pollMode);
	endproperty
	a_null: assert property (p_null)
		else $error("null command changed state");
	property p_go_local;
		@(posedge core_clk) disable iff (reset)
		clkEn && cmdStrobe && listener &&
		cmd == ibus_pkg::CMD_GO_LOCAL |=> !remote;
	endproperty
	a_go_local: assert property (p_go_local)
		else $error("remote kept after go-to-local");
	property p_key_free;
		@(posedge core_clk) disable iff (reset)
		clkEn && localKey && !lockout |=> !remote;
	endproperty
	a_key_free: assert property (p_key_free)
		else $error("local key ignored without lockout");
	property p_last_byte;
		@(posedge core_clk) disable iff (reset)
		clkEn && dataStrobe && busByte.eoi |=> lastByte;
	endproperty
	a_last_byte: assert property (p_last_byte)
		else $error("end flag not marked");
	property p_poll_talk;
		@(posedge core_clk) disable iff (reset)
		clkEn && pollMode && talker |=> sendStatus;
	endproperty
	a_poll_talk: assert property (p_poll_talk)
		else $error("status byte not selected in poll");
	property p_ifc_idle;
		@(posedge core_clk) disable iff (reset)
		clkEn && ifc |=> state == ST_IDLE;
	endproperty
	a_ifc_idle: assert property (p_ifc_idle)
		else $error("interface not idle after clear");
	c_listen: cover property (@(posedge core_clk) disable iff (reset)
		!listener ##1 listener);
	c_poll: cover property (@(posedge core_clk) disable iff (reset)
		sendStatus);
	c_trig: cover property (@(posedge core_clk) disable iff (reset)
		triggerPulse);
	c_full: cover property (@(posedge core_clk) disable iff (reset)
		!fifoInReady);
endmodule : ibus_iface
`default_nettype wire

// ### ibus_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Bus controller model
// ************************************************************
module ibus_ctrl_model (
	// Clock
	input wire logic core_clk,
	// Management lines
	output logic atn,
	output logic ren,
	output logic ifc,
	// Byte transfer
	output logic byteValid,
	output ibus_pkg::bus_byte_s busByte
);
	// Quiet bus at time zero
	initial begin
		atn = 1'b0;
		ren = 1'b0;
		ifc = 1'b0;
		byteValid = 1'b0;
		busByte = '0;
	end
	// One byte; attention high marks an encoded command, low marks text
	task automatic put(input logic a, input logic [8:0] b);
		@(posedge core_clk);
		atn <= a;
		byteValid <= 1'b1;
		busByte <= b;
		@(posedge core_clk);
		byteValid <= 1'b0;
		// Released lines change, so a stale byte is never read as valid
		busByte <= ~b;
	endtask : put
	// Remote enable and interface clear levels
	task automatic lines(input logic r, input logic i);
		@(posedge core_clk);
		ren <= r;
		ifc <= i;
	endtask : lines
endmodule : ibus_ctrl_model
`default_nettype wire

// ### instrument_bus_interface_commands_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	failures++; $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); \
	end end
module instrument_bus_interface_commands_tb;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [4:0] cfgAddr = 5'h05;
	logic cfgAddrValid = 1'b0;
	logic talkOnly = 1'b0;
	logic localKey = 1'b0;
	logic dataReady = 1'b1;
	logic clkEn = 1'b1;
	logic [7:0] statusBits = 8'h00;
	logic [7:0] statusEnable = 8'h00;
	logic atn, ren, ifc, byteValid, dataValid, inReady;
	ibus_pkg::bus_byte_s busByte, dataByte;
	logic [4:0] myAddr;
	logic listener, talker, remote, lockout, pollMode, sendStatus;
	logic srq, ppResponse, clearPulse, triggerPulse, lastByte;
	logic [8:0] lastData = '0;
	int failures = 0;
	int samples_checked = 0;
	int trigCount = 0;
	int clearCount = 0;
	int lastCount = 0;
	int dataCount = 0;
	// ************************************************************
	// Clock, parts and pulse counters
	// ************************************************************
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	ibus_ctrl_model ctrl_u (.core_clk(core_clk), .atn(atn), .ren(ren),
		.ifc(ifc), .byteValid(byteValid), .busByte(busByte));
	ibus_iface dut_u (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
		.cfgAddr(cfgAddr), .cfgAddrValid(cfgAddrValid), .talkOnly(talkOnly),
		.atn(atn), .ren(ren), .ifc(ifc), .byteValid(byteValid),
		.busByte(busByte), .localKey(localKey), .statusBits(statusBits),
		.statusEnable(statusEnable), .dataValid(dataValid),
		.dataReady(dataReady), .dataByte(dataByte), .inReady(inReady),
		.myAddr(myAddr), .listener(listener), .talker(talker),
		.remote(remote), .lockout(lockout), .pollMode(pollMode),
		.sendStatus(sendStatus), .srq(srq), .ppResponse(ppResponse),
		.clearPulse(clearPulse), .triggerPulse(triggerPulse),
		.lastByte(lastByte));
	// Counting pulses also catches a pulse that sticks high
	always @(posedge core_clk) begin
		if (triggerPulse === 1'b1) trigCount <= trigCount + 1;
		if (clearPulse === 1'b1) clearCount <= clearCount + 1;
		if (lastByte === 1'b1) lastCount <= lastCount + 1;
		if (dataValid === 1'b1) begin
			dataCount <= dataCount + 1;
			lastData <= dataByte;
		end
	end
	// ************************************************************
	// Access tasks
	// ************************************************************
	task automatic cmd(input logic [7:0] c);
		ctrl_u.put(1'b1, {1'b0, c});
		// Registered pulses are counted one edge after they stand
		repeat (2) @(negedge core_clk);
	endtask : cmd
	task automatic dat(input logic [8:0] b);
		ctrl_u.put(1'b0, b);
		@(negedge core_clk);
	endtask : dat
	task automatic lines(input logic r, input logic i);
		ctrl_u.lines(r, i);
		repeat (2) @(negedge core_clk);
	endtask : lines
	task automatic setAddr(input logic [4:0] a, input logic ok);
		@(posedge core_clk);
		cfgAddr <= a;
		cfgAddrValid <= ok;
		repeat (3) @(negedge core_clk);
	endtask : setAddr
	task automatic finish_test();
		$display("Counts: %0d checked, %0d failed", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test
	// Watchdog, well beyond the few hundred cycles the tests need
	initial begin
		repeat (4000) @(posedge core_clk);
		failures++;
		finish_test();
	end
	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		@(negedge core_clk);
		`CHK(myAddr, 5'h03)
		setAddr(5'h1f, 1'b1);
		`CHK(myAddr, 5'h03)
		setAddr(5'h1e, 1'b1);
		`CHK(myAddr, 5'h1e)
		setAddr(5'h05, 1'b0);
		`CHK(myAddr, 5'h03)
		setAddr(5'h05, 1'b1);
		// A frozen block takes no byte at all
		@(posedge core_clk);
		clkEn <= 1'b0;
		cmd(8'h25);
		`CHK({myAddr, listener}, {5'h05, 1'b0})
		@(posedge core_clk);
		clkEn <= 1'b1;
		$display("Test address done");
		lines(1'b1, 1'b0);
		cmd(8'h25);
		`CHK({listener, remote}, 2'b11)
		cmd(8'h26);
		cmd(ibus_pkg::CMD_NULL);
		`CHK({listener, talker}, 2'b10)
		cmd(8'h45);
		`CHK(talker, 1'b1)
		cmd(8'h46);
		`CHK(talker, 1'b0)
		cmd(8'h45);
		cmd(ibus_pkg::CMD_UNTALK);
		`CHK(talker, 1'b0)
		cmd(8'h45);
		cmd(ibus_pkg::CMD_POLL_ON);
		`CHK({pollMode, sendStatus}, 2'b11)
		cmd(ibus_pkg::CMD_POLL_OFF);
		`CHK({pollMode, sendStatus}, 2'b00)
		// Without lockout the local key hands control back
		@(posedge core_clk);
		localKey <= 1'b1;
		@(posedge core_clk);
		localKey <= 1'b0;
		repeat (2) @(negedge core_clk);
		`CHK({remote, lockout}, 2'b00)
		cmd(8'h25);
		cmd(ibus_pkg::CMD_LOCKOUT);
		@(posedge core_clk);
		localKey <= 1'b1;
		@(posedge core_clk);
		localKey <= 1'b0;
		repeat (2) @(negedge core_clk);
		`CHK({remote, lockout}, 2'b11)
		cmd(ibus_pkg::CMD_GO_LOCAL);
		`CHK({remote, lockout}, 2'b01)
		cmd(8'h25);
		lines(1'b0, 1'b0);
		`CHK({remote, lockout}, 2'b00)
		$display("Test addressing and remote done");
		cmd(ibus_pkg::CMD_TRIGGER);
		cmd(ibus_pkg::CMD_SEL_CLEAR);
		`CHK({trigCount, clearCount}, {32'd1, 32'd1})
		cmd(ibus_pkg::CMD_UNLISTEN);
		`CHK(listener, 1'b0)
		cmd(ibus_pkg::CMD_TRIGGER);
		cmd(ibus_pkg::CMD_SEL_CLEAR);
		cmd(ibus_pkg::CMD_DEV_CLEAR);
		`CHK({trigCount, clearCount}, {32'd1, 32'd2})
		cmd(8'h25);
		cmd(8'h45);
		lines(1'b0, 1'b1);
		`CHK({listener, talker}, 2'b00)
		lines(1'b0, 1'b0);
		$display("Test clear and trigger done");
		cmd(8'h25);
		@(posedge core_clk);
		dataReady <= 1'b0;
		for (int i = 0; i < 8; i++) dat({i == 7, 8'h30 + 8'(i)});
		repeat (2) @(negedge core_clk);
		`CHK(inReady, 1'b0)
		dat(9'h0ff);
		@(posedge core_clk);
		dataReady <= 1'b1;
		repeat (20) @(negedge core_clk);
		`CHK({dataCount, lastCount}, {32'd8, 32'd1})
		`CHK(lastData, 9'h137)
		cmd(8'h3a);
		repeat (4) @(negedge core_clk);
		`CHK(dataCount, 8)
		@(posedge core_clk);
		dataReady <= 1'b0;
		for (int i = 0; i < 3; i++) dat(9'h041);
		cmd(ibus_pkg::CMD_DEV_CLEAR);
		@(posedge core_clk);
		dataReady <= 1'b1;
		repeat (10) @(negedge core_clk);
		`CHK({dataCount, 31'd0, inReady}, {32'd8, 32'd1})
		$display("Test buffer done");
		@(posedge core_clk);
		statusBits <= 8'h04;
		repeat (3) @(negedge core_clk);
		`CHK(srq, 1'b0)
		@(posedge core_clk);
		statusEnable <= 8'h04;
		repeat (3) @(negedge core_clk);
		`CHK(srq, 1'b1)
		cmd(ibus_pkg::CMD_UNLISTEN);
		@(posedge core_clk);
		talkOnly <= 1'b1;
		cmd(8'h25);
		dat(9'h042);
		repeat (6) @(negedge core_clk);
		`CHK({listener, talker, dataCount}, {2'b01, 32'd8})
		`CHK(ppResponse, 1'b0)
		$display("Test service and output-only done");
		finish_test();
	end
endmodule : instrument_bus_interface_commands_tb
`default_nettype wire
